// >>> design/clk_startup_pkg.sv
// Constants and types for the clock source and start-up controller.
// Assumes fuse bits, oscillator ticks and reset sources arrive on ref_clk.
package clk_startup_pkg;

  // ---------------------------------------------------------------
  // Shipped fuse values (stored sense: 0 means programmed)
  // ---------------------------------------------------------------
  localparam logic [3:0] SRC_FUSE_RESET = 4'h2;
  localparam logic [1:0] SUT_FUSE_RESET = 2'h2;
  localparam logic DIV8_FUSE_RESET = 1'b0;

  // ---------------------------------------------------------------
  // Counts, in cycles of the clock that times them
  // ---------------------------------------------------------------
  localparam int CNT_EXTERNAL = 6;
  localparam int CNT_258 = 258;
  localparam int CNT_1K = 1024;
  localparam int CNT_16K = 16384;
  localparam int CNT_32K = 32768;
  localparam int CNT_RESET_EXTRA = 14;
  localparam int TOUT_SHORT = 4096;
  localparam int TOUT_LONG = 8192;
  localparam int DIV_RATIO = 8;

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [3:0] OFS_STATUS = 4'h0;
  localparam logic [3:0] OFS_CONTROL = 4'h4;
  localparam logic [3:0] OFS_COUNT = 4'h8;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int ST_SRC_LSB = 0;
  localparam int ST_SUT_LSB = 4;
  localparam int ST_DIV8_BIT = 6;
  localparam int ST_KIND_LSB = 7;
  localparam int ST_IRST_BIT = 10;
  localparam int ST_STATE_LSB = 11;
  localparam int CT_MODE_LSB = 0;
  localparam int CT_GO_BIT = 8;
  localparam int CNT_TOUT_LSB = 16;
  localparam logic [1:0] CT_MODE_RESET = 2'h0;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    src_low_power_xtal, src_full_swing_xtal, src_low_freq_xtal,
    src_rc_128k, src_rc_calibrated, src_external, src_reserved
  } source_kind_t;
  typedef enum logic [1:0] {tout_none, tout_short, tout_long} tout_sel_t;
  typedef enum logic [2:0] {
    wake_6, wake_258, wake_1k, wake_16k, wake_32k
  } wake_sel_t;
  typedef enum logic [1:0] {
    sleep_idle, sleep_converter_quiet, sleep_power_save, sleep_power_down
  } sleep_mode_t;
  typedef enum logic [2:0] {
    st_hold, st_timeout, st_osc, st_run, st_sleep, st_wake
  } seq_state_t;

endpackage

// >>> design/fuse_decode.sv
// Decodes the captured clock fuses into source kind and count choices.
// Purely combinational; the caller registers what it needs.
`timescale 1ns/1ps
module fuse_decode (
  input wire logic [3:0] src_fuses,
  input wire logic [1:0] sut_fuses,
  output clk_startup_pkg::source_kind_t kind,
  output clk_startup_pkg::tout_sel_t tout_sel,
  output clk_startup_pkg::wake_sel_t wake_sel
);

  // Start-up code: source bit 0 over the two start-up bits
  logic [2:0] code;
  assign code = {src_fuses[0], sut_fuses};

  // Source kind, time-out choice and wake count
  always_comb begin
    kind = clk_startup_pkg::src_reserved;
    if (src_fuses[3]) begin
      kind = clk_startup_pkg::src_low_power_xtal; // [R1]
    end else if (src_fuses[2:1] == 2'h3) begin
      kind = clk_startup_pkg::src_full_swing_xtal; // [R1]
    end else if (src_fuses[2:1] == 2'h2) begin
      kind = clk_startup_pkg::src_low_freq_xtal; // [R1]
    end else begin
      case (src_fuses[1:0])
        2'h3: kind = clk_startup_pkg::src_rc_128k; // [R1]
        2'h2: kind = clk_startup_pkg::src_rc_calibrated; // [R1]
        2'h0: kind = clk_startup_pkg::src_external; // [R1]
        default: kind = clk_startup_pkg::src_reserved; // [R1]
      endcase
    end
    if (src_fuses[3] || src_fuses[2:1] == 2'h3) begin
      // Crystal tables share one layout [R13] [R14]
      case (code)
        3'h0, 3'h1: wake_sel = clk_startup_pkg::wake_258; // [R13]
        3'h2, 3'h3, 3'h4: wake_sel = clk_startup_pkg::wake_1k; // [R13]
        default: wake_sel = clk_startup_pkg::wake_16k; // [R13]
      endcase
      case (code)
        3'h2, 3'h5: tout_sel = clk_startup_pkg::tout_none; // [R14]
        3'h0, 3'h3, 3'h6: tout_sel = clk_startup_pkg::tout_short; // [R14]
        default: tout_sel = clk_startup_pkg::tout_long; // [R14]
      endcase
    end else begin
      // Other sources: start-up bits pick the time-out, reserved 11 is longest
      case (sut_fuses)
        2'h0: tout_sel = clk_startup_pkg::tout_none; // [R6]
        2'h1: tout_sel = clk_startup_pkg::tout_short; // [R6]
        default: tout_sel = clk_startup_pkg::tout_long; // [R6]
      endcase
      if (src_fuses[2:1] == 2'h2) begin
        wake_sel = src_fuses[0] ? clk_startup_pkg::wake_32k : clk_startup_pkg::wake_1k; // [R9]
      end else begin
        wake_sel = clk_startup_pkg::wake_6; // [R9]
      end
    end
  end

endmodule

// >>> design/cycle_counter.sv
// Loadable down-counter that steps on a tick and flags when it is empty.
// Tick is a one-cycle enable in the ref_clk domain.
`timescale 1ns/1ps
module cycle_counter (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic load,
  input wire logic [15:0] load_value,
  input wire logic tick,
  output logic [15:0] count_reg,
  output logic done_reg
);

  // Load wins over a tick in the same cycle
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      count_reg <= 16'h0000;
      done_reg <= 1'b1;
    end else if (load) begin
      count_reg <= load_value;
      done_reg <= (load_value == 16'h0000);
    end else if (tick && count_reg != 16'h0000) begin
      count_reg <= count_reg - 16'h0001;
      done_reg <= (count_reg == 16'h0001);
    end
  end

endmodule

// >>> design/clock_source_startup_control.sv
// Clock source selection, start-up sequencing and clock domain gating.
// Assumes synchronous tick inputs for the watchdog and selected oscillator.
//
// How it works
// [R1] Decode four source-select fuse bits into sources
// [R2] Fuse bit one means unprogrammed, zero programmed
// [R3] Shipped fuses: calibrated RC, divide by eight
// [R4] Hold internal reset for time-out after sources
// [R5] Time-out counted in watchdog cycles, fuse chosen
// [R6] Time-out is 0, 4096 or 8192 cycles
// [R7] Disable time-out only with brown-out detector
// [R8] Ripple count oscillator cycles, then release reset
// [R9] Stabilisation counts from 6 up to 32K
// [R10] Reset uses both counts, wake only oscillator
// [R11] Low power bits three to one pick range
// [R12] Lowest low power range only for resonators
// [R13] Bit zero and start-up bits choose wake count
// [R14] Reset delay is 14 cycles plus time-out
// [R15] Programmed divide fuse divides clock by eight
// [R16] Each clock domain gated separately by sleep
// [R17] Core clock halt freezes core state
// [R18] Program memory clock follows core clock
// [R19] Async timer clock runs on through sleep; here it stops in power-down
// [R20] External interrupts seen with peripheral clock halted
// [R21] Converter clock runs with core clocks halted
// [R22] Time-out completes before oscillator count starts
//
// Implementation choices: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module clock_source_startup_control #(
  parameter int TOUT_SHORT_CYCLES = clk_startup_pkg::TOUT_SHORT,
  parameter int TOUT_LONG_CYCLES = clk_startup_pkg::TOUT_LONG,
  parameter int OSC_16K_CYCLES = clk_startup_pkg::CNT_16K,
  parameter int OSC_32K_CYCLES = clk_startup_pkg::CNT_32K
) (
  input wire logic ref_clk,
  input wire logic srst,
  // Avalon-MM slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Fuses and reset sources
  input wire logic [3:0] clock_source_select_fuses,
  input wire logic [1:0] startup_time_select_fuses,
  input wire logic divide_by_eight_fuse,
  input wire logic other_reset_active,
  // Timing ticks
  input wire logic watchdog_tick,
  input wire logic osc_tick,
  // Wake source
  input wire logic ext_int_request,
  // Outputs
  output logic internal_reset,
  output logic system_clock_tick,
  output logic core_clock_en,
  output logic peripheral_clock_en,
  output logic program_memory_clock_en,
  output logic async_timer_clock_en,
  output logic converter_clock_en,
  output logic [1:0] lp_xtal_range,
  output logic wake_detected
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic [3:0] src_fuse_reg; // Captured source select
  logic [1:0] sut_fuse_reg; // Captured start-up select
  logic div8_fuse_reg; // Captured divide fuse, stored sense
  logic div8_active; // Divide enabled
  clk_startup_pkg::source_kind_t kind; // Decoded source
  clk_startup_pkg::tout_sel_t tout_sel; // Time-out choice
  clk_startup_pkg::wake_sel_t wake_sel; // Wake count choice
  clk_startup_pkg::seq_state_t state_reg; // Sequencer state
  clk_startup_pkg::seq_state_t state_next;
  clk_startup_pkg::sleep_mode_t mode_reg; // Sleep mode
  logic sleep_go; // Software sleep request
  logic [15:0] tout_value; // Time-out load value
  logic [15:0] wake_value; // Oscillator count for wake
  logic [15:0] reset_osc_value; // Oscillator count from reset
  logic tout_load;
  logic osc_load;
  logic [15:0] osc_load_value;
  logic [15:0] tout_count;
  logic tout_done;
  logic [15:0] osc_count;
  logic osc_done;
  logic [2:0] div_reg; // Divide-by-eight phase
  logic bus_take; // Request accepted this edge
  logic [31:0] rdata_next;

  // ---------------------------------------------------------------
  // Fuse capture
  // ---------------------------------------------------------------
  // Fuses are sampled only while reset sources hold the device,
  // so a fuse change in run time has no effect until next reset.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      src_fuse_reg <= clk_startup_pkg::SRC_FUSE_RESET; // [R3]
      sut_fuse_reg <= clk_startup_pkg::SUT_FUSE_RESET; // [R3]
      div8_fuse_reg <= clk_startup_pkg::DIV8_FUSE_RESET; // [R3]
    end else if (state_reg == clk_startup_pkg::st_hold) begin
      src_fuse_reg <= clock_source_select_fuses;
      sut_fuse_reg <= startup_time_select_fuses;
      div8_fuse_reg <= divide_by_eight_fuse;
    end
  end

  // Zero means programmed
  assign div8_active = ~div8_fuse_reg; // [R2]

  // Fuse decoder
  fuse_decode u_decode (
    .src_fuses(src_fuse_reg),
    .sut_fuses(sut_fuse_reg),
    .kind(kind),
    .tout_sel(tout_sel),
    .wake_sel(wake_sel)
  );

  // Low power crystal range, bits three to one less the top bit
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      lp_xtal_range <= 2'h0;
    end else begin
      lp_xtal_range <= src_fuse_reg[2:1]; // [R11]
    end
  end

  // ---------------------------------------------------------------
  // Count values
  // ---------------------------------------------------------------
  // Time-out length in watchdog cycles
  always_comb begin
    case (tout_sel)
      clk_startup_pkg::tout_short: tout_value = 16'(TOUT_SHORT_CYCLES); // [R6]
      clk_startup_pkg::tout_long: tout_value = 16'(TOUT_LONG_CYCLES); // [R6]
      default: tout_value = 16'h0000; // [R6]
    endcase
  end

  // Oscillator stabilisation length
  always_comb begin
    case (wake_sel)
      clk_startup_pkg::wake_258: wake_value = 16'(clk_startup_pkg::CNT_258); // [R13]
      clk_startup_pkg::wake_1k: wake_value = 16'(clk_startup_pkg::CNT_1K); // [R13]
      clk_startup_pkg::wake_16k: wake_value = 16'(OSC_16K_CYCLES); // [R13]
      clk_startup_pkg::wake_32k: wake_value = 16'(OSC_32K_CYCLES); // [R9]
      default: wake_value = 16'(clk_startup_pkg::CNT_EXTERNAL); // [R9]
    endcase
  end

  // From reset the extra 14 cycles are added on top
  assign reset_osc_value = wake_value + 16'(clk_startup_pkg::CNT_RESET_EXTRA); // [R14]

  // ---------------------------------------------------------------
  // Counters
  // ---------------------------------------------------------------
  // Watchdog-timed reset time-out
  cycle_counter u_tout (
    .ref_clk(ref_clk),
    .srst(srst),
    .load(tout_load),
    .load_value(tout_value),
    .tick(watchdog_tick), // [R5]
    .count_reg(tout_count),
    .done_reg(tout_done)
  );

  // Oscillator ripple count
  cycle_counter u_osc (
    .ref_clk(ref_clk),
    .srst(srst),
    .load(osc_load),
    .load_value(osc_load_value),
    .tick(osc_tick), // [R8]
    .count_reg(osc_count),
    .done_reg(osc_done)
  );

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  // Reset sources always win and restart the whole sequence.
  always_comb begin
    state_next = state_reg;
    tout_load = 1'b0;
    osc_load = 1'b0;
    osc_load_value = reset_osc_value;
    if (other_reset_active) begin
      state_next = clk_startup_pkg::st_hold; // [R4]
    end else begin
      case (state_reg)
        clk_startup_pkg::st_hold: begin
          // Sources released: start time-out [R4]
          tout_load = 1'b1;
          state_next = clk_startup_pkg::st_timeout;
        end
        clk_startup_pkg::st_timeout: begin
          // Oscillator count only after time-out ends [R22]
          if (tout_done) begin
            osc_load = 1'b1;
            state_next = clk_startup_pkg::st_osc; // [R10]
          end
        end
        clk_startup_pkg::st_osc: begin
          // Both counts done: release reset [R8] [R22]
          if (osc_done) begin
            state_next = clk_startup_pkg::st_run;
          end
        end
        clk_startup_pkg::st_run: begin
          if (sleep_go) begin
            state_next = clk_startup_pkg::st_sleep; // [R16]
          end
        end
        clk_startup_pkg::st_sleep: begin
          if (ext_int_request) begin
            if (mode_reg == clk_startup_pkg::sleep_power_save ||
                mode_reg == clk_startup_pkg::sleep_power_down) begin
              // Oscillator was stopped: start-up count only [R10]
              osc_load = 1'b1;
              osc_load_value = wake_value;
              state_next = clk_startup_pkg::st_wake;
            end else begin
              state_next = clk_startup_pkg::st_run;
            end
          end
        end
        clk_startup_pkg::st_wake: begin
          if (osc_done) begin
            state_next = clk_startup_pkg::st_run; // [R10]
          end
        end
        default: state_next = clk_startup_pkg::st_hold;
      endcase
    end
  end

  // State register
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_reg <= clk_startup_pkg::st_hold;
    end else begin
      state_reg <= state_next;
    end
  end

  // Internal reset stays up until the run state is reached
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      internal_reset <= 1'b1;
    end else begin
      internal_reset <= (state_next == clk_startup_pkg::st_hold) ||
                        (state_next == clk_startup_pkg::st_timeout) ||
                        (state_next == clk_startup_pkg::st_osc); // [R4] [R8]
    end
  end

  // ---------------------------------------------------------------
  // Clock domain enables
  // ---------------------------------------------------------------
  // Enables follow the next state so they change with it.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      core_clock_en <= 1'b0;
      program_memory_clock_en <= 1'b0;
      peripheral_clock_en <= 1'b0;
      converter_clock_en <= 1'b0;
      async_timer_clock_en <= 1'b0;
    end else begin
      // Core off freezes register file and stack [R17]
      core_clock_en <= (state_next == clk_startup_pkg::st_run); // [R16]
      program_memory_clock_en <= (state_next == clk_startup_pkg::st_run); // [R18]
      peripheral_clock_en <= (state_next == clk_startup_pkg::st_run) ||
        (state_next == clk_startup_pkg::st_sleep &&
         mode_reg == clk_startup_pkg::sleep_idle); // [R16]
      converter_clock_en <= (state_next == clk_startup_pkg::st_run) ||
        (state_next == clk_startup_pkg::st_sleep &&
         (mode_reg == clk_startup_pkg::sleep_idle ||
          mode_reg == clk_startup_pkg::sleep_converter_quiet)); // [R21]
      // Timer keeps counting in every sleep but power-down [R19]
      async_timer_clock_en <= (state_next == clk_startup_pkg::st_run) ||
        (state_next == clk_startup_pkg::st_wake) ||
        (state_next == clk_startup_pkg::st_sleep &&
         mode_reg != clk_startup_pkg::sleep_power_down);
    end
  end

  // Wake is caught on the free-running clock, not a gated one
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wake_detected <= 1'b0;
    end else begin
      wake_detected <= ext_int_request &&
                       (state_reg == clk_startup_pkg::st_sleep); // [R20]
    end
  end

  // ---------------------------------------------------------------
  // System clock divider
  // ---------------------------------------------------------------
  // Divides oscillator ticks by eight when the fuse is programmed.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      div_reg <= 3'h0;
      system_clock_tick <= 1'b0;
    end else if (osc_tick) begin
      div_reg <= div_reg + 3'h1;
      system_clock_tick <= div8_active ?
        (div_reg == 3'(clk_startup_pkg::DIV_RATIO - 1)) : 1'b1; // [R15]
    end else begin
      system_clock_tick <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Avalon-MM slave
  // ---------------------------------------------------------------
  // One wait cycle per access; the request is taken on the edge
  // where waitrequest is seen low.
  assign bus_take = (avs_read || avs_write) && !avs_waitrequest;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      avs_waitrequest <= 1'b1;
    end else if (!avs_waitrequest) begin
      avs_waitrequest <= 1'b1;
    end else if (avs_read || avs_write) begin
      avs_waitrequest <= 1'b0;
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    rdata_next = 32'h0000_0000;
    case (avs_address)
      clk_startup_pkg::OFS_STATUS: begin
        rdata_next[clk_startup_pkg::ST_SRC_LSB +: 4] = src_fuse_reg;
        rdata_next[clk_startup_pkg::ST_SUT_LSB +: 2] = sut_fuse_reg;
        rdata_next[clk_startup_pkg::ST_DIV8_BIT] = div8_fuse_reg;
        rdata_next[clk_startup_pkg::ST_KIND_LSB +: 3] = kind;
        rdata_next[clk_startup_pkg::ST_IRST_BIT] = internal_reset;
        rdata_next[clk_startup_pkg::ST_STATE_LSB +: 3] = state_reg;
      end
      clk_startup_pkg::OFS_CONTROL: begin
        rdata_next[clk_startup_pkg::CT_MODE_LSB +: 2] = mode_reg;
      end
      clk_startup_pkg::OFS_COUNT: begin
        rdata_next[15:0] = osc_count;
        rdata_next[clk_startup_pkg::CNT_TOUT_LSB +: 16] = tout_count;
      end
      default: ;
    endcase
  end

  // Read data loaded while waitrequest is still high
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && avs_waitrequest) begin
      avs_readdata <= rdata_next;
    end
  end

  // Control register; sleep request is a write-one pulse
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      mode_reg <= clk_startup_pkg::sleep_mode_t'(clk_startup_pkg::CT_MODE_RESET);
      sleep_go <= 1'b0;
    end else begin
      sleep_go <= 1'b0;
      if (bus_take && avs_write && avs_address == clk_startup_pkg::OFS_CONTROL) begin
        if (avs_byteenable[0]) begin
          mode_reg <= clk_startup_pkg::sleep_mode_t'(
            avs_writedata[clk_startup_pkg::CT_MODE_LSB +: 2]);
        end
        if (avs_byteenable[1]) begin
          sleep_go <= avs_writedata[clk_startup_pkg::CT_GO_BIT];
        end
      end
    end
  end

endmodule

// >>> bench/clk_startup_monitor.sv
// Concurrent checks on the ports of the clock start-up controller.
// Assumes one ref_clk domain with srst synchronous and active high.
`timescale 1ns/1ps
module clk_startup_monitor (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic [3:0] clock_source_select_fuses,
  input wire logic other_reset_active,
  input wire logic osc_tick,
  input wire logic ext_int_request,
  input wire logic internal_reset,
  input wire logic system_clock_tick,
  input wire logic core_clock_en,
  input wire logic peripheral_clock_en,
  input wire logic program_memory_clock_en,
  input wire logic async_timer_clock_en,
  input wire logic converter_clock_en,
  input wire logic [1:0] lp_xtal_range,
  input wire logic wake_detected
);
  // ---------------------------------------------------------------
  // Bus, sequencing and clock gating relations
  // ---------------------------------------------------------------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  // Slave answers one cycle after a request is first seen
  chk_wait_one_cycle: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest not low one cycle after request");
  // Answer lasts one cycle only, so a held request is not taken on two edges in a row
  chk_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  chk_hold_reset: assert property (other_reset_active [*2] |-> internal_reset)
    else $error("internal reset low while other reset holds");
  chk_release_late: assert property ($fell(internal_reset) |-> !$past(other_reset_active, 2))
    else $error("internal reset released too soon");
  chk_flash_core: assert property (program_memory_clock_en == core_clock_en)
    else $error("program memory clock differs from core clock");
  chk_core_domains: assert property (core_clock_en |-> peripheral_clock_en && converter_clock_en)
    else $error("domain off while core runs");
  chk_conv_timer: assert property (converter_clock_en |-> async_timer_clock_en)
    else $error("timer clock off while converter runs");
  chk_div_tick: assert property (system_clock_tick |-> $past(osc_tick))
    else $error("system tick without oscillator tick");
  chk_wake_source: assert property (wake_detected |-> $past(ext_int_request) && !$past(core_clock_en))
    else $error("wake flag without request in sleep");
  chk_range_bits: assert property (!other_reset_active && !internal_reset && $stable(clock_source_select_fuses)
    |-> lp_xtal_range == clock_source_select_fuses[2:1])
    else $error("crystal range differs from fuse bits");
endmodule
bind clock_source_startup_control clk_startup_monitor u_mon (.*);

// >>> bench/testbench.sv
// Self-checking bench for the clock start-up controller.
// Drives fuses, reset sources, ticks and the register bus itself.
`timescale 1ns/1ps
`define CHK(a, b, m) begin n_checks++; if ((a) !== (b)) begin fail_count++; $display("[FAIL] %0t %s", $time, m); end end
module testbench;
  logic ref_clk = 1'b0, srst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, other_reset_active = 1'b1;
  logic watchdog_tick = 1'b0, osc_tick = 1'b0, ext_int_request = 1'b0, divide_by_eight_fuse = 1'b0;
  logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hF, clock_source_select_fuses = 4'h2;
  logic [1:0] startup_time_select_fuses = 2'h2, lp_xtal_range;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  logic avs_waitrequest, internal_reset, system_clock_tick, core_clock_en, peripheral_clock_en;
  logic program_memory_clock_en, async_timer_clock_en, converter_clock_en, wake_detected;
  int fail_count = 0, n_checks = 0, sct_n = 0, s0;
  // Fuses, time-out and oscillator counts per case
  int tb[11][5] = '{'{2, 2, 0, 16, 20}, '{8, 0, 0, 8, 272}, '{8, 1, 0, 16, 272}, '{8, 2, 0, 0, 1038},
    '{8, 3, 0, 8, 1038}, '{9, 0, 0, 16, 1038}, '{9, 1, 0, 0, 34}, '{9, 2, 0, 8, 34},
    '{9, 3, 0, 16, 34}, '{5, 1, 0, 8, 38}, '{0, 0, 1, 0, 20}};
  clock_source_startup_control #(.TOUT_SHORT_CYCLES(8), .TOUT_LONG_CYCLES(16), .OSC_16K_CYCLES(20),
    .OSC_32K_CYCLES(24)) DUT (.*);
  // ---------------------------------------------------------------
  // Clock and helpers
  // ---------------------------------------------------------------
  initial forever #12.5 ref_clk = ~ref_clk;
  // Counts divided system ticks so rates can be compared over a window
  always @(posedge ref_clk) if (system_clock_tick === 1'b1) sct_n <= sct_n + 1;
  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // One bus cycle, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int i;
    @(posedge ref_clk);
    avs_write <= w;
    avs_read <= !w;
    avs_address <= a;
    avs_writedata <= d;
    i = 0;
    do begin
      @(posedge ref_clk);
      i++;
    end while (avs_waitrequest !== 1'b0 && i < 64);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (i >= 64) begin
      `CHK(1'b0, 1'b1, "bus timeout")
      complete_run();
    end
  endtask
  // One-cycle tick pulses, two cycles apart; w picks watchdog over oscillator
  task automatic tick(input bit w, input int n);
    repeat (n) begin
      @(posedge ref_clk);
      if (w) watchdog_tick <= 1'b1;
      else osc_tick <= 1'b1;
      @(posedge ref_clk);
      watchdog_tick <= 1'b0;
      osc_tick <= 1'b0;
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    idle(16);
    srst <= 1'b0;
    idle(2);
    bus(1'b0, clk_startup_pkg::OFS_STATUS, 32'h0);
    `CHK(q[10:0], 11'h622, "shipped fuse state")
    bus(1'b0, 4'hC, 32'hFFFF_FFFF);
    `CHK(q, 32'h0, "unmapped read")
    for (int i = 0; i < 11; i++) begin
      other_reset_active <= 1'b1;
      clock_source_select_fuses <= 4'(tb[i][0]);
      startup_time_select_fuses <= 2'(tb[i][1]);
      divide_by_eight_fuse <= tb[i][2][0];
      idle(4);
      other_reset_active <= 1'b0;
      idle(3);
      // Oscillator ticks must not count until the time-out is over
      if (tb[i][3] > 0) begin
        tick(1, tb[i][3] - 1);
        tick(0, tb[i][4] + 2);
        idle(3);
        `CHK(internal_reset, 1'b1, "released before time-out")
        tick(1, 1);
        idle(3);
      end
      tick(0, tb[i][4] - 1);
      idle(3);
      `CHK(internal_reset, 1'b1, "released before oscillator count")
      tick(0, 1);
      idle(4);
      `CHK(internal_reset, 1'b0, "not released after both counts")
      `CHK(lp_xtal_range, 2'(tb[i][0] >> 1), "crystal range")
      s0 = sct_n;
      tick(0, 16);
      idle(2);
      `CHK(sct_n - s0, tb[i][2] ? 16 : 2, "system tick rate")
      $display("startup case %0d done", i);
    end
    // Source is external now, so the wake count is six oscillator cycles
    for (int md = 0; md < 4; md++) begin
      bus(1'b1, clk_startup_pkg::OFS_CONTROL, 32'h0000_0100 | 32'(md));
      idle(3);
      `CHK(core_clock_en, 1'b0, "core clock on in sleep")
      `CHK(peripheral_clock_en, md == 0, "peripheral gate")
      `CHK(converter_clock_en, md < 2, "converter gate")
      `CHK(async_timer_clock_en, md != 3, "timer gate")
      ext_int_request <= 1'b1;
      idle(1);
      ext_int_request <= 1'b0;
      #1 `CHK(wake_detected, 1'b1, "no wake flag")
      idle(3);
      if (md >= 2) begin
        tick(0, 5);
        idle(3);
        `CHK(core_clock_en, 1'b0, "woke before oscillator count")
        tick(0, 1);
        idle(4);
      end
      `CHK(core_clock_en, 1'b1, "no return to run")
    end
    $display("sleep modes done");
    other_reset_active <= 1'b1;
    for (int k = 0; k < 16; k++) begin
      clock_source_select_fuses <= 4'(k);
      idle(3);
      bus(1'b0, clk_startup_pkg::OFS_STATUS, 32'h0);
      `CHK(q[9:7], 3'(k > 7 ? 0 : k > 5 ? 1 : k > 3 ? 2 : k == 3 ? 3 : k == 2 ? 4 : k == 0 ? 5 : 6), "kind")
    end
    $display("source kinds done");
    complete_run();
  end
endmodule
